/* rtl/tsk_sensor_ctrl.sv */
// Module: clock division, channel masking, start-up and serial slave port
`timescale 1ns/100ps

// Summary of operation
// - Oscillator rate is nominal times trim factor 0.5..1.75; reset 100 gives one.
// - Internal clock is oscillator divided by 1, 4, 16 or 64.
// - Sample rate is internal clock over 8; channels sampled in turn.
// - Secondary mode stops internal generator, timing from external clock pin.
// - Unused clock register bit written zero; reads may return either.
// - Every clock register bit is writable and readable by command.
// - Channel enable mask, one bit per channel, resets all ones.
// - Masked-sampling off: disabled channels sampled but cannot update state.
// - Masked-sampling on: disabled channels skipped entirely.
// - A newly enabled channel runs fast start-up.
// - Serial port and registers stay alive while regulated domain is off.
// - Power-on resets all registers; regulator starts enabled.
// - Each channel charges fast, then fine steps, then enables counters.
// - Start-up runs independently per channel.
// - Data pin is input or open-drain output driving only low.
// - One bit per clock pulse; data stable while clock high.
// - Falling data with clock high is start; rising is stop.
// - Each byte acknowledged; addressed slave acknowledges received bytes.
// - Acknowledger holds data low through acknowledge clock high phase.
// - Master read not acknowledged ends send; slave releases data line.
// - Slave address 010000 plus address-select pin plus read/write.
// - Coarse field 00 /64, 01 /16 reset, 10 /4, 11 /1.
// - Secondary mode inverts external clock to replace internal clock.
module tsk_sensor_ctrl
  import tsk_pkg::*;
#(
  parameter logic [7:0] FAST_THRESHOLD = 8'hC0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic ext_clk_in,
  input wire logic [7:0] sensor_event,
  input wire logic [7:0] cap_level,
  output logic [7:0] sensor_state_register,
  output logic [7:0] sample_strobe,
  output logic [7:0] counters_enable,
  output logic [7:0] fast_charge,
  output logic [7:0] fine_charge,
  output logic regulator_off_bit,
  output logic masked_sampling_select,
  output logic sample_clk
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] clock_setting_register;
  logic [7:0] chan_enable_bits;
  logic [7:0] config_reg;
  logic [2:0] osc_trim_field;
  logic [1:0] coarse_clk_divider_field;
  logic secondary_mode;

  assign osc_trim_field = clock_setting_register[TSK_TRIM_LSB +: 3];
  assign coarse_clk_divider_field = clock_setting_register[TSK_COARSE_LSB +: 2];
  assign masked_sampling_select = config_reg[TSK_CFG_MASKED_SAMPLING_SELECT_BIT];
  assign regulator_off_bit = config_reg[TSK_CFG_REGOFF_BIT];
  assign secondary_mode = config_reg[TSK_CFG_SECONDARY_BIT];
  // ****************************************
  // Serial bus edge detection
  // ****************************************
  logic scl_q, sda_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl & scl_q & ~sda_q & sda_in;
  // ****************************************
  // Serial slave state machine
  // ****************************************
  tsk_state_type state;
  logic [7:0] shift;
  logic [2:0] bitcnt;
  logic [1:0] bytecnt;
  logic [7:0] cmd;
  logic reading;
  logic ack_drive;
  logic [7:0] tx_data;
  always_comb begin
    unique case (cmd)
      TSK_CMD_RD_CLOCK: tx_data = clock_setting_register;
      TSK_CMD_RD_MASK: tx_data = chan_enable_bits;
      TSK_CMD_RD_CONFIG: tx_data = config_reg;
      default: tx_data = sensor_state_register;
    endcase
  end
  logic wr_strobe;
  assign wr_strobe = (state == TSK_RECV) && scl_rise && (bitcnt == 3'h7)
    && (bytecnt == 2'h2);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= TSK_IDLE;
      shift <= 8'h00;
      bitcnt <= 3'h0;
      bytecnt <= 2'h0;
      cmd <= 8'h00;
      reading <= 1'b0;
      ack_drive <= 1'b0;
    end else if (start_cond) begin
      state <= TSK_RECV;
      bitcnt <= 3'h0;
      bytecnt <= 2'h0;
      reading <= 1'b0;
      ack_drive <= 1'b0;
    end else if (stop_cond) begin
      state <= TSK_IDLE;
      cmd <= 8'h00;
      ack_drive <= 1'b0;
    end else begin
      unique case (state)
        TSK_IDLE: ack_drive <= 1'b0;
        TSK_RECV: if (scl_rise) begin
          shift <= {shift[6:0], sda_in};
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            state <= TSK_ACK;
            if (bytecnt == 2'h0) begin
              if ({shift[6:1], shift[0]} ==
                  {TSK_ADDR_FIXED, addr_select_pin}) begin
                reading <= sda_in;
              end else begin
                state <= TSK_IDLE;
              end
            end else begin
              if (bytecnt == 2'h1) cmd <= {shift[6:0], sda_in};
            end
          end
        end
        // pull low from the fall after bit 8 until the next fall
        TSK_ACK: if (scl_fall && !ack_drive) begin
          ack_drive <= 1'b1;
        end else if (scl_fall) begin
          ack_drive <= 1'b0;
          if (bytecnt != 2'h2) bytecnt <= bytecnt + 2'h1;
          if (reading) begin
            state <= TSK_SEND;
            shift <= tx_data;
          end else begin
            state <= TSK_RECV;
          end
        end
        TSK_SEND: if (scl_fall) begin
          shift <= {shift[6:0], 1'b0};
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) state <= TSK_MACK;
        end
        TSK_MACK: if (scl_rise) begin
          if (sda_in) state <= TSK_IDLE;
        end else if (scl_fall) begin
          state <= TSK_SEND;
          shift <= tx_data;
        end
        default: state <= TSK_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sda_oe <= 1'b0;
    else sda_oe <= (state == TSK_ACK && ack_drive) ||
      (state == TSK_SEND && !shift[7]);
  end
  assign sda_out = 1'b0;
  // ****************************************
  // Register writes
  // ****************************************
  // registers live in the always-on domain, no regulator dependence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_setting_register <= TSK_CLOCK_SETTING_REGISTER_RESET;
      chan_enable_bits <= TSK_MASK_RESET;
      config_reg <= TSK_CFG_RESET;
    end else if (wr_strobe) begin
      unique case (cmd)
        // unused bit stored as written, read back unchanged
        TSK_CMD_WR_CLOCK: clock_setting_register <= {shift[6:0], sda_in};
        TSK_CMD_WR_MASK: chan_enable_bits <= {shift[6:0], sda_in};
        TSK_CMD_WR_CONFIG: config_reg <= {shift[6:0], sda_in};
        default: ;
      endcase
    end
  end
  // ****************************************
  // Clock generation
  // ****************************************
  // Trimmed oscillator modelled as a phase accumulator; overflow is a tick.
  // step = 8 * factor in eighths, carry at 64 gives nominal/8 rate
  logic [6:0] osc_acc;
  logic osc_tick;
  logic [5:0] trim_step;
  assign trim_step = osc_trim_field[2] ? {2'h0, osc_trim_field, 1'b0} :
    TSK_TRIM_BASE + {3'h0, osc_trim_field};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_acc <= 7'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_acc <= {1'b0, osc_acc[5:0]} + {1'b0, trim_step};
      osc_tick <= osc_acc[6];
    end
  end
  logic [5:0] div_cnt;
  logic [5:0] div_max;
  always_comb begin
    unique case (coarse_clk_divider_field)
      TSK_DIV64: div_max = 6'h3F;
      TSK_DIV16: div_max = 6'h0F;
      TSK_DIV4: div_max = 6'h03;
      TSK_DIV1: div_max = 6'h00;
    endcase
  end
  logic ext_q, int_tick, clk_tick;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 6'h00;
      int_tick <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clk_in;
      int_tick <= 1'b0;
      if (secondary_mode) begin
        div_cnt <= 6'h00;
      end else if (osc_tick) begin
        if (div_cnt >= div_max) begin
          div_cnt <= 6'h00;
          int_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end
    end
  end
  // inverted external clock, tick on its falling edge
  assign clk_tick = secondary_mode ? (ext_q & ~ext_clk_in) : int_tick;
  // sequential channel sampling, one channel per internal clock
  logic [2:0] chan_idx;
  logic [2:0] div8;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_idx <= 3'h0;
      div8 <= 3'h0;
      sample_clk <= 1'b0;
    end else if (clk_tick) begin
      div8 <= div8 + 3'h1;
      sample_clk <= (div8 < 3'h4);
      chan_idx <= chan_idx + 3'h1;
    end
  end
  // ****************************************
  // Per-channel sampling and start-up
  // ****************************************
  logic [7:0] en_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) en_q <= TSK_MASK_RESET;
    else en_q <= chan_enable_bits;
  end

  generate
    for (genvar i = 0; i < TSK_NCHAN; i++) begin : g_chan
      tsk_chan_type cst;
      logic [7:0] fine_cnt;
      logic hit;
      // skip disabled channels when masked sampling is on
      assign hit = clk_tick && (chan_idx == 3'(i)) &&
        (chan_enable_bits[i] || !masked_sampling_select);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) sample_strobe[i] <= 1'b0;
        else sample_strobe[i] <= hit;
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cst <= TSK_CH_FAST;
          fine_cnt <= 8'h00;
        end else if (chan_enable_bits[i] && !en_q[i]) begin
          cst <= TSK_CH_FAST;
          fine_cnt <= 8'h00;
        end else if (hit) begin
          unique case (cst)
            TSK_CH_FAST: if (cap_level >= FAST_THRESHOLD) cst <= TSK_CH_FINE;
            TSK_CH_FINE: begin
              fine_cnt <= fine_cnt + 8'h01;
              if (fine_cnt == TSK_FINE_STEPS - 8'h01) cst <= TSK_CH_RUN;
            end
            TSK_CH_RUN: ;
            default: cst <= TSK_CH_FAST;
          endcase
        end
      end
      assign fast_charge[i] = (cst == TSK_CH_FAST);
      assign fine_charge[i] = (cst == TSK_CH_FINE);
      assign counters_enable[i] = (cst == TSK_CH_RUN);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sensor_state_register[i] <= 1'b0;
        // only enabled, running channels update the state
        end else if (hit && chan_enable_bits[i] && cst == TSK_CH_RUN) begin
          sensor_state_register[i] <= sensor_event[i];
        end
      end
    end
  endgenerate
endmodule : tsk_sensor_ctrl

/* rtl/tsk_pkg.sv */
// Package: constants and types for the touch sensor clock, mask and serial port
package tsk_pkg;
  // ****************************************
  // Clock setting register
  // ****************************************
  localparam logic [2:0] TSK_TRIM_RESET = 3'h4;
  localparam logic [1:0] TSK_COARSE_RESET = 2'h1;
  localparam logic [1:0] TSK_DIV64 = 2'h0;
  localparam logic [1:0] TSK_DIV16 = 2'h1;
  localparam logic [1:0] TSK_DIV4 = 2'h2;
  localparam logic [1:0] TSK_DIV1 = 2'h3;
  localparam int TSK_TRIM_LSB = 0;
  localparam int TSK_COARSE_LSB = 3;
  localparam int TSK_UNUSED_BIT = 5;
  localparam int TSK_CLKIN_BIT = 6;
  localparam int TSK_CLKOUT_BIT = 7;
  localparam logic [7:0] TSK_CLOCK_SETTING_REGISTER_RESET = 8'h0C;
  localparam logic [7:0] TSK_MASK_RESET = 8'hFF;
  localparam logic [7:0] TSK_CFG_RESET = 8'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam int TSK_SAMPLE_DIV = 8;
  localparam int TSK_NCHAN = 8;
  localparam logic [7:0] TSK_FINE_STEPS = 8'h10;
  // Trim phase accumulator: step = 8*m, m in eighths (0.5 -> 4)
  localparam logic [5:0] TSK_TRIM_BASE = 6'h04;
  // ****************************************
  // Serial addressing and commands
  // ****************************************
  localparam logic [5:0] TSK_ADDR_FIXED = 6'h10;
  localparam logic [7:0] TSK_CMD_WR_CLOCK = 8'h01;
  localparam logic [7:0] TSK_CMD_RD_CLOCK = 8'h02;
  localparam logic [7:0] TSK_CMD_WR_MASK = 8'h03;
  localparam logic [7:0] TSK_CMD_RD_MASK = 8'h04;
  localparam logic [7:0] TSK_CMD_WR_CONFIG = 8'h05;
  localparam logic [7:0] TSK_CMD_RD_CONFIG = 8'h06;
  localparam int TSK_CFG_MASKED_SAMPLING_SELECT_BIT = 0;
  localparam int TSK_CFG_REGOFF_BIT = 1;
  localparam int TSK_CFG_SECONDARY_BIT = 2;

  typedef enum logic [4:0] {
    TSK_IDLE = 5'h01,
    TSK_RECV = 5'h02,
    TSK_ACK = 5'h04,
    TSK_SEND = 5'h08,
    TSK_MACK = 5'h10
  } tsk_state_type;

  typedef enum logic [3:0] {
    TSK_CH_OFF = 4'h1,
    TSK_CH_FAST = 4'h2,
    TSK_CH_FINE = 4'h4,
    TSK_CH_RUN = 4'h8
  } tsk_chan_type;

  typedef struct packed {
    logic scl;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
  } tsk_bus_type;
endpackage : tsk_pkg

/* verification/tsk_sensor_monitor.sv */
// Checker: serial port and start-up sequencing assertions
`timescale 1ns/100ps
module tsk_sensor_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] sample_strobe,
  input wire logic [7:0] counters_enable,
  input wire logic [7:0] fast_charge,
  input wire logic [7:0] fine_charge
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ******************************
  // Bus and start-up sequences
  // ******************************
  sequence s_start;
    scl && $fell(sda_in);
  endsequence
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_reset_values: assert property ($rose(rstn) |->
    !sda_oe && fast_charge == 8'hFF && counters_enable == 8'h00)
    else $error("outputs not at reset values");
  a_strobe_onehot: assert property ($onehot0(sample_strobe))
    else $error("two channels sampled at once");
  a_strobe_single: assert property (|sample_strobe |=>
    (sample_strobe & $past(sample_strobe)) == 8'h00)
    else $error("sample strobe longer than one cycle");
  a_phase_exclusive: assert property (
    (counters_enable & (fast_charge | fine_charge)) == 8'h00 &&
    (fast_charge & fine_charge) == 8'h00)
    else $error("start-up phases overlap");
  a_fine_then_run: assert property (
    (counters_enable & ~$past(counters_enable) & ~$past(fine_charge))
    == 8'h00)
    else $error("counters enabled without fine phase");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data pin changed while clock high");
  a_start_quiet: assert property (s_start |=> s_quiet)
    else $error("slave drove data right after start");
endmodule : tsk_sensor_monitor

bind tsk_sensor_ctrl tsk_sensor_monitor u_mon (
  .clk(clk),
  .rstn(rstn),
  .scl(scl),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .sample_strobe(sample_strobe),
  .counters_enable(counters_enable),
  .fast_charge(fast_charge),
  .fine_charge(fine_charge)
);

/* verification/tsk_bus_master.sv */
// Partner: two-wire bus master model of the system controller
`timescale 1ns/100ps
module tsk_bus_master #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: both lines high through the pull-ups
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // data moves only while clock low
  task automatic put(input logic d, output logic q);
    wt(1);
    sda_low <= !d;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    q = sda;
    scl <= 1'b0;
  endtask : put
  task automatic start();
    wt(1);
    sda_low <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_low <= 1'b1;
    wt(HALF);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(1);
    sda_low <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_low <= 1'b0;
    wt(HALF);
  endtask : stop
  // master acknowledges all but the last byte read
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put(d[i], b);
      q[i] = b;
    end
    put(!mack, b);
    ack = !b;
  endtask : xfer
endmodule : tsk_bus_master

/* verification/test_touch_sensor_clock_mask_i2c_port.sv */
// Testbench: register access, clock division and masking checks
`timescale 1ns/100ps
module test_touch_sensor_clock_mask_i2c_port
  import tsk_pkg::*;
;
  logic clk, rstn, pin, ext_clk, clr, sda_out, sda_oe, regoff, mmode, sclk;
  logic [7:0] ev, cap, state, strobe, cnt_en, fast, fine, seen;
  logic sc_d = 1'b0;
  wire scl, sda, sda_low;
  int fail_count = 0, total_checks = 0, period = 0, pcnt = 0;
  assign sda = ~((sda_oe & ~sda_out) | sda_low);
  tsk_sensor_ctrl dut (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(pin),
    .ext_clk_in(ext_clk), .sensor_event(ev), .cap_level(cap),
    .sensor_state_register(state), .sample_strobe(strobe),
    .counters_enable(cnt_en), .fast_charge(fast), .fine_charge(fine),
    .regulator_off_bit(regoff), .masked_sampling_select(mmode),
    .sample_clk(sclk));
  tsk_bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Sample clock period and strobes seen since the last clear
  always @(posedge clk) begin
    sc_d <= sclk;
    pcnt <= (sclk && !sc_d) ? 1 : pcnt + 1;
    if (sclk && !sc_d) period <= pcnt;
    seen <= clr ? 8'h00 : seen | strobe;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] q;
    logic a, b, e;
    m.start();
    m.xfer(8'h42, 1'b0, q, a);
    m.xfer(c, 1'b0, q, b);
    m.xfer(v, 1'b0, q, e);
    m.stop();
    chk({a, b, e}, 3'h7);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] q;
    logic a, b;
    m.start();
    m.xfer(8'h42, 1'b0, q, a);
    m.xfer(c, 1'b0, q, a);
    m.start();
    m.xfer(8'h43, 1'b0, q, a);
    m.xfer(8'hFF, 1'b0, q, b);
    chk(sda_oe, 1'b0);
    m.stop();
    chk({a, q}, {1'b1, exp});
  endtask : rd
  task automatic settle(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : settle
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic [7:0] q;
    logic [7:0] cv [3] = '{8'h14, 8'h18, 8'h1C};
    int pv [3] = '{256, 128, 64};
    logic a, s;
    rstn = 1'b0;
    pin = 1'b1;
    ext_clk = 1'b0;
    clr = 1'b0;
    ev = 8'h00;
    cap = 8'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(TSK_CMD_RD_CLOCK, 8'h0C);
    rd(TSK_CMD_RD_MASK, 8'hFF);
    rd(TSK_CMD_RD_CONFIG, 8'h00);
    m.start();
    m.xfer(8'h40, 1'b0, q, a);
    m.stop();
    chk(a, 1'b0);
    // Trim 1.5 with divide-by-4: 170.67 cycles, so 170 or 171 per period
    wr(TSK_CMD_WR_CLOCK, 8'h16);
    settle(700);
    chk(period / 2, 85);
    for (int i = 0; i < 3; i++) begin
      wr(TSK_CMD_WR_CLOCK, cv[i]);
      rd(TSK_CMD_RD_CLOCK, cv[i]);
      settle(700);
      chk(period, pv[i]);
    end
    chk({fast, cnt_en}, 16'hFF00);
    cap <= 8'hFF;
    settle(2000);
    chk({fast, cnt_en}, 16'h00FF);
    wr(TSK_CMD_WR_MASK, 8'h0F);
    rd(TSK_CMD_RD_MASK, 8'h0F);
    cap <= 8'h00;
    wr(TSK_CMD_WR_MASK, 8'hFF);
    settle(200);
    chk({fast, cnt_en}, 16'hF00F);
    cap <= 8'hFF;
    settle(2000);
    wr(TSK_CMD_WR_MASK, 8'h0F);
    wr(TSK_CMD_WR_CONFIG, 8'h01);
    settle(300);
    chk({mmode, seen}, 9'h10F);
    wr(TSK_CMD_WR_CONFIG, 8'h00);
    ev <= 8'hFF;
    settle(300);
    chk(seen, 8'hFF);
    m.start();
    m.xfer(8'h43, 1'b0, q, a);
    m.xfer(8'hFF, 1'b1, q, a);
    chk(q, 8'h0F);
    m.xfer(8'hFF, 1'b0, q, a);
    m.stop();
    chk(q, 8'h0F);
    wr(TSK_CMD_WR_CONFIG, 8'h02);
    rd(TSK_CMD_RD_CONFIG, 8'h02);
    chk(regoff, 1'b1);
    wr(TSK_CMD_WR_CONFIG, 8'h04);
    settle(20);
    s = sclk;
    settle(300);
    chk(sclk, s);
    // External clock of 10 cycles: eight falling edges per sample period
    repeat (400) begin
      ext_clk <= ~ext_clk;
      repeat (5) @(posedge clk);
    end
    chk(period, 80);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(TSK_CMD_RD_CLOCK, 8'h0C);
    report_and_stop();
  end
endmodule : test_touch_sensor_clock_mask_i2c_port
